//--- hdl/pdc_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef PDC_REGS_SVH
`define PDC_REGS_SVH

// register offsets
`define PDC_OFF_PAD_PAIR_5_6_CFG 8'h10
`define PDC_OFF_PAD_PAIR_7_8_CFG 8'h11
`define PDC_OFF_VIDEO_AUDIO_PATH_CONTROL 8'h12
`define PDC_OFF_STRAP_MODE_STATUS 8'h13

// pad-pair register fields
`define PDC_PAD_HI_LEVEL_BIT 7
`define PDC_PAD_HI_CFG_MSB 5
`define PDC_PAD_HI_CFG_LSB 4
`define PDC_PAD_LO_LEVEL_BIT 3
`define PDC_PAD_LO_CFG_MSB 1
`define PDC_PAD_LO_CFG_LSB 0
`define PDC_PAD_WRITE_MASK 8'hBB

// datapath control fields
`define PDC_DP_RSVD_RW_BIT 6
`define PDC_DP_DE_INVERT_BIT 5
`define PDC_DP_REGEN_BIT 4
`define PDC_DP_B_OVERRIDE_BIT 3
`define PDC_DP_NARROW_BIT 2
`define PDC_DP_TRANSPORT_BIT 1
`define PDC_DP_B_ENABLE_BIT 0
`define PDC_DP_WRITE_MASK 8'h7F

// status fields
`define PDC_ST_B_LATCHED_BIT 7
`define PDC_ST_B_LEVEL_MSB 6
`define PDC_ST_B_LEVEL_LSB 4
`define PDC_ST_A_LATCHED_BIT 3
`define PDC_ST_A_LEVEL_MSB 2
`define PDC_ST_A_LEVEL_LSB 0

// reset values
`define PDC_RST_PAD_PAIR 8'h00
`define PDC_RST_PATH_CONTROL 8'h00

// strap settling: sample window before latching
`define PDC_STRAP_SETTLE_NS 1000
`define PDC_CLK_PERIOD_NS 20
`define PDC_STRAP_SETTLE_CYC \
  ((`PDC_STRAP_SETTLE_NS + `PDC_CLK_PERIOD_NS - 1) / `PDC_CLK_PERIOD_NS)

`endif

//--- hdl/pdc_pkg.sv
// types shared by the pad and datapath configuration block
package pdc_pkg;

  // pad configuration, {direction, enable}
  typedef enum logic [1:0] {
    PDC_PAD_FUNC_IN = 2'b00,
    PDC_PAD_GP_OUT = 2'b01,
    PDC_PAD_HIGH_Z = 2'b10,
    PDC_PAD_GP_IN = 2'b11
  } pdc_pad_mode_t;

  // strap capture sequence
  typedef enum logic [1:0] {
    PDC_STRAP_SETTLE = 2'b00,
    PDC_STRAP_DONE = 2'b01
  } pdc_strap_state_t;

endpackage

//--- hdl/pdc_pad_ctrl.sv
// one general-purpose pad: drive, enable and input selection
`timescale 1ns/1ns
module pdc_pad_ctrl (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // configuration
  input wire logic [1:0] config_in,
  input wire logic out_level_in,
  // pad and core side
  input wire logic pad_sync_in,
  output logic pad_drive_out,
  output logic pad_oe_out,
  output logic gp_in_level_out,
  output logic func_in_out
);

  // ----------------------------------------------------------------
  // pad decode
  // ----------------------------------------------------------------

  // output enable and value only in general-purpose output mode
  // drive gating
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pad_drive_out <= 1'b0;
      pad_oe_out <= 1'b0;
      gp_in_level_out <= 1'b0;
      func_in_out <= 1'b0;
    end else begin
      pad_oe_out <= (config_in == pdc_pkg::PDC_PAD_GP_OUT);
      pad_drive_out <= (config_in == pdc_pkg::PDC_PAD_GP_OUT) ?
                       out_level_in : 1'b0;
      gp_in_level_out <= (config_in == pdc_pkg::PDC_PAD_GP_IN) ?
                         pad_sync_in : 1'b0;
      func_in_out <= (config_in == pdc_pkg::PDC_PAD_FUNC_IN) ?
                     pad_sync_in : 1'b0;
    end
  end

  AST_PAD_DRIVE: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    $past(config_in) == pdc_pkg::PDC_PAD_GP_OUT |->
      pad_oe_out && pad_drive_out == $past(out_level_in))
    else $error("pad not driven with stored level");

  AST_PAD_NO_DRIVE: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    $past(config_in) != pdc_pkg::PDC_PAD_GP_OUT |-> !pad_oe_out)
    else $error("pad driven outside output mode");

endmodule

//--- hdl/pdc_config_regs.sv
// pad and datapath configuration registers with strap status
`timescale 1ns/1ns
`include "pdc_regs.svh"
module pdc_config_regs #(
  parameter int NUM_PADS = 4,
  parameter int STRAP_SETTLE_CYC = `PDC_STRAP_SETTLE_CYC
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // register port from the I2C target
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rvalid_out,
  // mode straps, decoded levels from pins
  input wire logic [2:0] strap_input_a_in,
  input wire logic [2:0] strap_input_b_in,
  // pads 5 to 8, index 0 is pad 5
  input wire logic [NUM_PADS-1:0] pad_in,
  output logic [NUM_PADS-1:0] pad_out,
  output logic [NUM_PADS-1:0] pad_oe_out,
  output logic [NUM_PADS-1:0] pad_gp_level_out,
  output logic [NUM_PADS-1:0] pad_func_out,
  // datapath controls
  input wire logic repeater_mode_in,
  input wire logic inband_b_valid_in,
  input wire logic inband_b_enable_in,
  input wire logic data_enable_in,
  output logic data_enable_out,
  output logic narrow_video_select_out,
  output logic frame_transport_out,
  output logic regen_from_i2s_pins_out,
  output logic passthru_from_video_out,
  output logic channel_b_enable_out
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------

  logic [7:0] pad_pair_5_6_cfg;
  logic [7:0] pad_pair_7_8_cfg;
  logic [7:0] video_audio_path_control;
  logic [2:0] strap_a_level;
  logic [2:0] strap_b_level;
  logic strap_a_latched;
  logic strap_b_latched;
  logic [2:0] strap_a_meta;
  logic [2:0] strap_a_sync;
  logic [2:0] strap_b_meta;
  logic [2:0] strap_b_sync;
  logic [NUM_PADS-1:0] pad_meta;
  logic [NUM_PADS-1:0] pad_sync;
  logic [15:0] settle_count;
  pdc_pkg::pdc_strap_state_t strap_state;
  logic [7:0] strap_mode_status;
  logic [1:0] pad_cfg [NUM_PADS];
  logic pad_level [NUM_PADS];
  logic next_b_enable;

  // ----------------------------------------------------------------
  // pad pair registers
  // ----------------------------------------------------------------

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pad_pair_5_6_cfg <= `PDC_RST_PAD_PAIR;
      pad_pair_7_8_cfg <= `PDC_RST_PAD_PAIR;
    end else if (reg_write_in) begin
      if (reg_addr_in == `PDC_OFF_PAD_PAIR_5_6_CFG) begin
        pad_pair_5_6_cfg <= reg_wdata_in & `PDC_PAD_WRITE_MASK;
      end
      if (reg_addr_in == `PDC_OFF_PAD_PAIR_7_8_CFG) begin
        pad_pair_7_8_cfg <= reg_wdata_in & `PDC_PAD_WRITE_MASK;
      end
    end
  end

  // ----------------------------------------------------------------
  // datapath control register
  // ----------------------------------------------------------------

  // bit 7 read-only, bit 6 writable
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      video_audio_path_control <= `PDC_RST_PATH_CONTROL;
    end else if (reg_write_in &&
                 reg_addr_in == `PDC_OFF_VIDEO_AUDIO_PATH_CONTROL) begin
      video_audio_path_control <= reg_wdata_in & `PDC_DP_WRITE_MASK;
    end
  end

  // ----------------------------------------------------------------
  // strap and pad synchronisers
  // ----------------------------------------------------------------

  // two flops on strap and pad pins
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      strap_a_meta <= 3'h0;
      strap_a_sync <= 3'h0;
      strap_b_meta <= 3'h0;
      strap_b_sync <= 3'h0;
      pad_meta <= '0;
      pad_sync <= '0;
    end else begin
      strap_a_meta <= strap_input_a_in;
      strap_a_sync <= strap_a_meta;
      strap_b_meta <= strap_input_b_in;
      strap_b_sync <= strap_b_meta;
      pad_meta <= pad_in;
      pad_sync <= pad_meta;
    end
  end

  // ----------------------------------------------------------------
  // strap capture
  // ----------------------------------------------------------------

  // settle after reset, then hold the strap levels
  // strap A and B levels
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      strap_state <= pdc_pkg::PDC_STRAP_SETTLE;
      settle_count <= 16'h0000;
      strap_a_level <= 3'h0;
      strap_b_level <= 3'h0;
    end else begin
      unique case (strap_state)
        pdc_pkg::PDC_STRAP_SETTLE: begin
          strap_a_level <= strap_a_sync;
          strap_b_level <= strap_b_sync;
          if (settle_count == 16'(STRAP_SETTLE_CYC - 1)) begin
            strap_state <= pdc_pkg::PDC_STRAP_DONE;
          end else begin
            settle_count <= settle_count + 16'h0001;
          end
        end
        pdc_pkg::PDC_STRAP_DONE: begin
          strap_state <= pdc_pkg::PDC_STRAP_DONE;
        end
        default: begin
          strap_state <= pdc_pkg::PDC_STRAP_SETTLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      strap_a_latched <= 1'b1;
      strap_b_latched <= 1'b1;
    end else begin
      strap_a_latched <= (strap_state == pdc_pkg::PDC_STRAP_DONE);
      strap_b_latched <= (strap_state == pdc_pkg::PDC_STRAP_DONE);
    end
  end

  // status layout
  always_comb begin
    strap_mode_status = {strap_b_latched, strap_b_level,
                         strap_a_latched, strap_a_level};
  end

  // ----------------------------------------------------------------
  // register read
  // ----------------------------------------------------------------

  // host read answer one cycle later
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reg_rdata_out <= 8'h00;
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_read_in;
      if (reg_read_in) begin
        unique case (reg_addr_in)
          `PDC_OFF_PAD_PAIR_5_6_CFG: reg_rdata_out <= pad_pair_5_6_cfg;
          `PDC_OFF_PAD_PAIR_7_8_CFG: reg_rdata_out <= pad_pair_7_8_cfg;
          `PDC_OFF_VIDEO_AUDIO_PATH_CONTROL: begin
            reg_rdata_out <= video_audio_path_control;
          end
          `PDC_OFF_STRAP_MODE_STATUS: reg_rdata_out <= strap_mode_status;
          default: reg_rdata_out <= 8'h00;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // pads
  // ----------------------------------------------------------------

  // pad fields unpacked per pad
  // field placement
  always_comb begin
    pad_cfg[0] = pad_pair_5_6_cfg[`PDC_PAD_LO_CFG_MSB:`PDC_PAD_LO_CFG_LSB];
    pad_cfg[1] = pad_pair_5_6_cfg[`PDC_PAD_HI_CFG_MSB:`PDC_PAD_HI_CFG_LSB];
    pad_cfg[2] = pad_pair_7_8_cfg[`PDC_PAD_LO_CFG_MSB:`PDC_PAD_LO_CFG_LSB];
    pad_cfg[3] = pad_pair_7_8_cfg[`PDC_PAD_HI_CFG_MSB:`PDC_PAD_HI_CFG_LSB];
    pad_level[0] = pad_pair_5_6_cfg[`PDC_PAD_LO_LEVEL_BIT];
    pad_level[1] = pad_pair_5_6_cfg[`PDC_PAD_HI_LEVEL_BIT];
    pad_level[2] = pad_pair_7_8_cfg[`PDC_PAD_LO_LEVEL_BIT];
    pad_level[3] = pad_pair_7_8_cfg[`PDC_PAD_HI_LEVEL_BIT];
  end

  // one pad controller per pad
  for (genvar i = 0; i < NUM_PADS; i++) begin : g_pad
    pdc_pad_ctrl u_pad (
      .sys_clk_in(sys_clk_in),
      .reset_n_in(reset_n_in),
      .config_in(pad_cfg[i]),
      .out_level_in(pad_level[i]),
      .pad_sync_in(pad_sync[i]),
      .pad_drive_out(pad_out[i]),
      .pad_oe_out(pad_oe_out[i]),
      .gp_in_level_out(pad_gp_level_out[i]),
      .func_in_out(pad_func_out[i])
    );
  end

  // ----------------------------------------------------------------
  // datapath controls
  // ----------------------------------------------------------------

  // channel-B enable selection
  // override gating
  always_comb begin
    next_b_enable = 1'b0;
    if (video_audio_path_control[`PDC_DP_B_OVERRIDE_BIT]) begin
      next_b_enable = video_audio_path_control[`PDC_DP_B_ENABLE_BIT];
    end
    if (repeater_mode_in && inband_b_valid_in) begin
      next_b_enable = inband_b_enable_in;
    end
  end

  // registered datapath outputs
  // enable polarity
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      data_enable_out <= 1'b0;
      narrow_video_select_out <= 1'b0;
      frame_transport_out <= 1'b0;
      regen_from_i2s_pins_out <= 1'b0;
      passthru_from_video_out <= 1'b0;
      channel_b_enable_out <= 1'b0;
    end else begin
      data_enable_out <= data_enable_in ^
                         video_audio_path_control[`PDC_DP_DE_INVERT_BIT];
      narrow_video_select_out <=
        video_audio_path_control[`PDC_DP_NARROW_BIT];
      frame_transport_out <=
        video_audio_path_control[`PDC_DP_TRANSPORT_BIT];
      regen_from_i2s_pins_out <= repeater_mode_in &&
        video_audio_path_control[`PDC_DP_REGEN_BIT];
      passthru_from_video_out <= repeater_mode_in &&
        !video_audio_path_control[`PDC_DP_REGEN_BIT];
      channel_b_enable_out <= next_b_enable;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------

  AST_PAD_RSVD_ZERO: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    pad_pair_5_6_cfg[6] == 1'b0 && pad_pair_5_6_cfg[2] == 1'b0 &&
    pad_pair_7_8_cfg[6] == 1'b0 && pad_pair_7_8_cfg[2] == 1'b0)
    else $error("pad reserved bit set");

  AST_DATA_ENABLE_INVERT: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    ##1 data_enable_out == ($past(data_enable_in) ^
      $past(video_audio_path_control[`PDC_DP_DE_INVERT_BIT])))
    else $error("data enable polarity wrong");

  AST_B_OVERRIDE_OFF: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    !video_audio_path_control[`PDC_DP_B_OVERRIDE_BIT] &&
    !(repeater_mode_in && inband_b_valid_in) |=> !channel_b_enable_out)
    else $error("channel B enabled without override");

  AST_NARROW_VIDEO: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    ##1 narrow_video_select_out ==
      $past(video_audio_path_control[`PDC_DP_NARROW_BIT]))
    else $error("video width select wrong");

  AST_DP_RSVD: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    video_audio_path_control[7] == 1'b0)
    else $error("datapath bit 7 set");

  AST_STRAP_DONE_HOLD: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    strap_state == pdc_pkg::PDC_STRAP_DONE |=> $stable(strap_b_level) &&
      $stable(strap_a_level))
    else $error("strap level changed after latch");

  AST_STATUS_RO: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    reg_write_in && reg_addr_in == `PDC_OFF_STRAP_MODE_STATUS &&
    strap_state == pdc_pkg::PDC_STRAP_DONE |=> $stable(strap_mode_status))
    else $error("status changed by write");

  AST_READ_ANSWER: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    reg_read_in && reg_addr_in == `PDC_OFF_VIDEO_AUDIO_PATH_CONTROL &&
    !reg_write_in |=>
      reg_rvalid_out && reg_rdata_out == $past(video_audio_path_control))
    else $error("read answer wrong");

endmodule

//--- tb/tb_pdc_config_regs.sv
// self-checking bench for the pad and datapath configuration registers
`timescale 1ns/1ns
module tb_pdc_config_regs;
  // ----------------------------------------
  // signals and bench state
  // ----------------------------------------
  localparam int SETTLE = 4;
  logic sys_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_write_in = 1'b0;
  logic reg_read_in = 1'b0;
  logic [7:0] reg_rdata_out;
  logic reg_rvalid_out;
  logic [2:0] strap_input_a_in = 3'h5;
  logic [2:0] strap_input_b_in = 3'h2;
  logic [3:0] pad_in = 4'h0;
  logic [3:0] pad_out, pad_oe_out, pad_gp_level_out, pad_func_out;
  logic repeater_mode_in = 1'b0;
  logic inband_b_valid_in = 1'b0;
  logic inband_b_enable_in = 1'b0;
  logic data_enable_in = 1'b0;
  logic data_enable_out, narrow_video_select_out, frame_transport_out;
  logic regen_from_i2s_pins_out, passthru_from_video_out;
  logic channel_b_enable_out;
  int n_mismatch = 0;
  int total_checks = 0;
  logic [1:0] md [4];
  logic [3:0] lv, e_oe, e_gp, e_fn;
  logic [5:0] v;

  // ----------------------------------------
  // design under test
  // ----------------------------------------
  pdc_config_regs #(.NUM_PADS(4), .STRAP_SETTLE_CYC(SETTLE))
    pdc_config_regs_inst (
    .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
    .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
    .strap_input_a_in(strap_input_a_in),
    .strap_input_b_in(strap_input_b_in),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe_out(pad_oe_out),
    .pad_gp_level_out(pad_gp_level_out), .pad_func_out(pad_func_out),
    .repeater_mode_in(repeater_mode_in),
    .inband_b_valid_in(inband_b_valid_in),
    .inband_b_enable_in(inband_b_enable_in),
    .data_enable_in(data_enable_in), .data_enable_out(data_enable_out),
    .narrow_video_select_out(narrow_video_select_out),
    .frame_transport_out(frame_transport_out),
    .regen_from_i2s_pins_out(regen_from_i2s_pins_out),
    .passthru_from_video_out(passthru_from_video_out),
    .channel_b_enable_out(channel_b_enable_out)
  );

  // 50 MHz clock
  initial begin
    forever #10 sys_clk_in = ~sys_clk_in;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  // counts a comparison and reports a mismatch
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // prints counts and verdict, then stops
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // one-cycle write strobe, changed on the falling edge
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(negedge sys_clk_in);
    reg_addr_in = addr;
    reg_wdata_in = data;
    reg_write_in = 1'b1;
    @(negedge sys_clk_in);
    reg_write_in = 1'b0;
  endtask

  // one-cycle read strobe, answer looked at one cycle later
  task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
    @(negedge sys_clk_in);
    reg_addr_in = addr;
    reg_read_in = 1'b1;
    @(negedge sys_clk_in);
    reg_read_in = 1'b0;
    check("read valid", {7'h00, reg_rvalid_out}, 8'h01);
    check("read data", reg_rdata_out, exp);
  endtask

  // pulses reset low for one cycle in mid-run
  task automatic pulse_reset();
    @(negedge sys_clk_in);
    reset_n_in = 1'b0;
    @(negedge sys_clk_in);
    reset_n_in = 1'b1;
  endtask

  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  initial begin
    repeat (20000) @(posedge sys_clk_in);
    n_mismatch++;
    $display("unexpected watchdog expected done seen hang");
    close_out();
  end

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(negedge sys_clk_in);
    reset_n_in = 1'b1;
    // reset values and strap capture
    rd(8'h10, 8'h00);
    rd(8'h11, 8'h00);
    rd(8'h12, 8'h00);
    check("pad enable", {4'h0, pad_oe_out}, 8'h00);
    repeat (SETTLE + 10) @(negedge sys_clk_in);
    rd(8'h13, 8'hAD);
    strap_input_a_in = 3'h2;
    strap_input_b_in = 3'h6;
    repeat (10) @(negedge sys_clk_in);
    rd(8'h13, 8'hAD);
    $display("test reset and straps done");
    // reserved, read-only and unmapped places
    wr(8'h10, 8'hFF);
    rd(8'h10, 8'hBB);
    wr(8'h11, 8'h44);
    rd(8'h11, 8'h00);
    wr(8'h12, 8'hFF);
    rd(8'h12, 8'h7F);
    wr(8'h13, 8'h00);
    rd(8'h13, 8'hAD);
    wr(8'h14, 8'hFF);
    rd(8'h14, 8'h00);
    $display("test access kinds done");
    // mid-run reset clears fields and recaptures straps
    pulse_reset();
    rd(8'h13, 8'h00);
    repeat (SETTLE + 10) @(negedge sys_clk_in);
    rd(8'h10, 8'h00);
    rd(8'h12, 8'h00);
    rd(8'h13, {1'b1, 3'h6, 1'b1, 3'h2});
    $display("test second reset done");
    // every pad mode and level, each pad different
    for (int k = 0; k < 8; k++) begin
      for (int i = 0; i < 4; i++) begin
        md[i] = k[1:0] ^ i[1:0];
        lv[i] = k[2] ^ i[0];
      end
      pad_in = {k[0], ~k[1], k[2], ~k[0]};
      wr(8'h10, {lv[1], 1'b0, md[1], lv[0], 1'b0, md[0]});
      wr(8'h11, {lv[3], 1'b0, md[3], lv[2], 1'b0, md[2]});
      repeat (4) @(negedge sys_clk_in);
      for (int i = 0; i < 4; i++) begin
        e_oe[i] = (md[i] == pdc_pkg::PDC_PAD_GP_OUT);
        e_gp[i] = (md[i] == pdc_pkg::PDC_PAD_GP_IN) & pad_in[i];
        e_fn[i] = (md[i] == pdc_pkg::PDC_PAD_FUNC_IN) & pad_in[i];
      end
      check("pad enable", {4'h0, pad_oe_out}, {4'h0, e_oe});
      check("pad level", {4'h0, pad_out & e_oe}, {4'h0, lv & e_oe});
      check("pad gp in", {4'h0, pad_gp_level_out}, {4'h0, e_gp});
      check("pad func in", {4'h0, pad_func_out}, {4'h0, e_fn});
      rd(8'h11, {lv[3], 1'b0, md[3], lv[2], 1'b0, md[2]});
    end
    $display("test pad modes done");
    // every datapath setting with repeater and in-band cases
    for (int k = 0; k < 128; k++) begin
      v = k[5:0];
      repeater_mode_in = k[6];
      inband_b_valid_in = k[1];
      inband_b_enable_in = ~k[0];
      data_enable_in = k[3] ^ k[6];
      wr(8'h12, {2'b00, v});
      @(negedge sys_clk_in);
      check("de out", {7'h0, data_enable_out},
            {7'h0, data_enable_in ^ v[5]});
      check("narrow", {7'h0, narrow_video_select_out}, {7'h0, v[2]});
      check("transport", {7'h0, frame_transport_out}, {7'h0, v[1]});
      check("regen", {7'h0, regen_from_i2s_pins_out},
            {7'h0, k[6] & v[4]});
      check("passthru", {7'h0, passthru_from_video_out},
            {7'h0, k[6] & ~v[4]});
      check("chan b", {7'h0, channel_b_enable_out},
            {7'h0, (k[6] & k[1]) ? ~k[0] : (v[3] & v[0])});
    end
    $display("test datapath done");
    close_out();
  end
endmodule
